// *** hw/sph_edge.sv ***
// Selected-edge and active-level detector for the input strobe
`default_nettype none
module sph_edge (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic level,
	input wire logic rising_sel,
	output logic edge_seen,
	output logic level_act
);
	logic prev_q;
	logic primed_q;

	// First sample after reset only primes, so a quiet line is no edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev_q <= 1'b0;
			primed_q <= 1'b0;
		end else if (ce) begin
			prev_q <= level;
			primed_q <= 1'b1;
		end
	end

	assign edge_seen = primed_q & (rising_sel ? (level & ~prev_q)
		: (~level & prev_q));
	assign level_act = rising_sel ? ~level : level;
endmodule : sph_edge
`default_nettype wire

// *** hw/sph_handshake.sv ***
// Strobed parallel handshake for ports B and C behind an AXI4-Lite slave
//
// Behaviour
// - Handshake functions work only while single-chip mode input is high.
// - Simple mode: port B strobed output, port C latching input, together.
// - In simple mode each port B data write drives the output strobe active two clocks.
// - Polarity bit 0 gives active-low output strobe, 1 active-high.
// - Each selected input strobe edge captures port C pins into the latch.
// - Edge select 0 falling edge, high level; 1 rising edge, low level.
// - Selected input strobe edge sets the event flag, control bit 7.
// - Flag clears on control read with flag set, then mode's latch access.
// - Interrupt request while flag set and interrupt enable is one.
// - Wired-OR select one makes all eight port C outputs open-drain.
// - Full handshake bit 0 selects simple mode, 1 full handshake.
// - Direction select counts only in full mode: 0 input, 1 output.
// - Full modes: interlocked strobe holds until edge; pulsed two clocks.
// - Input handshake: ready strobe; edge latches, negates; read rearms.
// - Output handshake: latch write asserts strobe; partner edge acks.
// - Three-state variant drives all port C lines while input strobe active.
// - Port C lines stay general-purpose I/O while strobed input works.
// - Control bit 7 read-only; reset clears 7..3, keeps 2, sets 1..0.
// - Output handshake: direction bits zero select the three-state option.
// - Latch reads return the value captured at the last selected edge.
//
// Design decision made here: the AXI4-Lite interface to the registers.
`default_nettype none
module sph_handshake
	import sph_pkg::*;
#(
	parameter int STROBE_LEN = sph_pkg::STROBE_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [sph_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [sph_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [sph_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [sph_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic single_chip_mode,
	output logic [sph_pkg::PORT_W-1:0] port_b_out,
	input wire logic [sph_pkg::PORT_W-1:0] port_c_in,
	output logic [sph_pkg::PORT_W-1:0] port_c_out,
	output logic [sph_pkg::PORT_W-1:0] port_c_oe_n,
	input wire logic strobe_in,
	output logic strobe_out,
	output logic strobe_irq
);
	localparam int CW = $clog2(STROBE_LEN + 1);
	localparam logic [CW-1:0] PULSE_LOAD = CW'(STROBE_LEN - 1);

	if (STROBE_LEN < 1) begin : g_bad_len
		$error("strobe pulse length must be at least one cycle");
	end

	logic [ADDR_W-1:0] aw_addr_q;
	logic aw_full_q;
	logic [7:0] w_data_q;
	logic w_strobe_out_q;
	logic w_full_q;
	logic wr_fire;
	logic wr_en;
	logic rd_fire;
	sph_reg_t wr_sel;
	sph_reg_t rd_sel;
	logic [7:0] ctrl_q;
	logic pulse_sel_q;
	logic flag_q;
	logic clr_arm_q;
	logic [7:0] port_b_q;
	logic [7:0] pc_data_q;
	logic [7:0] pc_dir_q;
	logic [7:0] latch_q;
	logic [7:0] ctrl_view;
	logic [7:0] pc_view;
	logic [7:0] rd_val;
	logic [8:0] sync_q;
	logic [7:0] pc_pin;
	logic stb_lvl;
	logic sel_edge_raw;
	logic sel_edge;
	logic lvl_act;
	logic simple_mode;
	logic in_hs;
	logic out_hs;
	logic lat_rd;
	logic lat_wr;
	logic ctrl_rd;
	logic clr_access;
	logic enter_in;
	logic pb_wr;
	logic trig;
	logic hold_go;
	logic strobe_act;
	logic [7:0] drive;
	sph_state_t st_q;
	logic [CW-1:0] cnt_q;

	// Write channel: address and data taken independently, then committed
	assign s_axi_awready = ce & ~aw_full_q & ~s_axi_bvalid;
	assign s_axi_wready = ce & ~w_full_q & ~s_axi_bvalid;
	assign wr_fire = ce & aw_full_q & w_full_q & ~s_axi_bvalid;
	assign wr_sel = sph_decode(aw_addr_q);
	assign wr_en = wr_fire & w_strobe_out_q & (wr_sel != R_NONE);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			aw_addr_q <= '0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_full_q <= 1'b0;
			end
		end
	end

	// Only byte lane 0 carries register data; upper lanes are ignored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_full_q <= 1'b0;
			w_data_q <= '0;
			w_strobe_out_q <= 1'b0;
		end else if (ce) begin
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_q <= 1'b1;
				w_data_q <= s_axi_wdata[7:0];
				w_strobe_out_q <= s_axi_wstrb[0];
			end else if (wr_fire) begin
				w_full_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (ce) begin
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wr_sel == R_NONE) ? RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read channel: one cycle to a registered answer
	assign s_axi_arready = ce & ~s_axi_rvalid;
	assign rd_fire = s_axi_arvalid & s_axi_arready;
	assign rd_sel = sph_decode(s_axi_araddr);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (ce) begin
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h000000, rd_val};
				s_axi_rresp <= (rd_sel == R_NONE) ? RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	assign ctrl_view = {flag_q, ctrl_q[6:3], pulse_sel_q, ctrl_q[1:0]};
	// Output lines read back the port C data register, input lines read the pins
	assign pc_view = (pc_dir_q & pc_data_q) | (~pc_dir_q & pc_pin);

	always_comb begin
		case (rd_sel)
			R_CTRL: rd_val = ctrl_view;
			R_PC_DATA: rd_val = pc_view;
			R_PB_DATA: rd_val = port_b_q;
			R_PC_LATCH: rd_val = latch_q;
			R_PC_DIR: rd_val = pc_dir_q;
			default: rd_val = 8'h00;
		endcase
	end

	// Pin side: strobe and port C pins share one synchroniser
	sph_sync #(
		.W(9)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.d({strobe_in, port_c_in}),
		.q(sync_q)
	);

	assign pc_pin = sync_q[7:0];
	assign stb_lvl = sync_q[8];

	sph_edge u_edge (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.level(stb_lvl),
		.rising_sel(ctrl_q[B_EDGE_SEL]),
		.edge_seen(sel_edge_raw),
		.level_act(lvl_act)
	);

	assign sel_edge = sel_edge_raw & single_chip_mode;

	// Mode decode
	assign simple_mode = single_chip_mode & ~ctrl_q[B_FULL_HS];
	assign in_hs = single_chip_mode & ctrl_q[B_FULL_HS]
		& ~ctrl_q[B_DIR_SEL];
	assign out_hs = single_chip_mode & ctrl_q[B_FULL_HS]
		& ctrl_q[B_DIR_SEL];

	assign ctrl_rd = rd_fire & (rd_sel == R_CTRL);
	assign lat_rd = rd_fire & (rd_sel == R_PC_LATCH);
	assign lat_wr = wr_en & (wr_sel == R_PC_LATCH);
	assign pb_wr = wr_en & (wr_sel == R_PB_DATA);
	assign clr_access = (lat_rd & ~out_hs) | (lat_wr & out_hs);
	assign enter_in = wr_en & (wr_sel == R_CTRL) & single_chip_mode
		& w_data_q[B_FULL_HS] & ~w_data_q[B_DIR_SEL] & ~in_hs;

	// Control register; the pulse select bit keeps its value over reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= CTRL_RESET;
		end else if (ce && wr_en && wr_sel == R_CTRL) begin
			ctrl_q <= {1'b0, w_data_q[6:0]};
		end
	end

	always_ff @(posedge aclk) begin
		if (ce && wr_en && wr_sel == R_CTRL) begin
			pulse_sel_q <= w_data_q[B_PULSE_SEL];
		end
	end

	// Event flag: a new edge wins over a clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flag_q <= 1'b0;
			clr_arm_q <= 1'b0;
		end else if (ce) begin
			if (sel_edge) begin
				flag_q <= 1'b1;
			end else if (clr_arm_q && clr_access) begin
				flag_q <= 1'b0;
			end
			if (ctrl_rd && flag_q) begin
				clr_arm_q <= 1'b1;
			end else if (clr_access) begin
				clr_arm_q <= 1'b0;
			end
		end
	end

	assign strobe_irq = flag_q & ctrl_q[B_IRQ_EN];

	// Capture latch
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			latch_q <= LATCH_RESET;
		end else if (ce && sel_edge) begin
			latch_q <= pc_pin;
		end
	end

	// Port data and direction; in output handshake a latch write feeds port C
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_b_q <= PB_RESET;
			pc_data_q <= PC_RESET;
			pc_dir_q <= DIR_RESET;
		end else if (ce) begin
			if (pb_wr) begin
				port_b_q <= w_data_q;
			end
			if ((wr_en && wr_sel == R_PC_DATA) || (lat_wr && out_hs)) begin
				pc_data_q <= w_data_q;
			end
			if (wr_en && wr_sel == R_PC_DIR) begin
				pc_dir_q <= w_data_q;
			end
		end
	end

	assign port_b_out = port_b_q;
	assign port_c_out = pc_data_q;

	// Output strobe sequencer
	assign trig = (simple_mode & pb_wr)
		| (in_hs & lat_rd) | enter_in
		| (out_hs & lat_wr);
	// Entering input handshake must use the mode bits being written now
	assign hold_go = enter_in ? ~w_data_q[B_PULSE_SEL]
		: (ctrl_q[B_FULL_HS] & ~pulse_sel_q);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= ST_IDLE;
			cnt_q <= '0;
		end else if (ce) begin
			if (!single_chip_mode) begin
				st_q <= ST_IDLE;
			end else begin
				case (st_q)
					ST_IDLE: begin
						if (trig && hold_go) begin
							st_q <= ST_HOLD;
						end else if (trig) begin
							st_q <= ST_PULSE;
							cnt_q <= PULSE_LOAD;
						end
					end
					ST_HOLD: begin
						if (sel_edge) begin
							st_q <= ST_IDLE;
						end
					end
					ST_PULSE: begin
						if (trig) begin
							cnt_q <= PULSE_LOAD;
						end else if (cnt_q == '0) begin
							st_q <= ST_IDLE;
						end else begin
							cnt_q <= cnt_q - CW'(1);
						end
					end
					default: st_q <= ST_IDLE;
				endcase
			end
		end
	end

	assign strobe_act = (st_q != ST_IDLE);
	assign strobe_out = ctrl_q[B_POLARITY] ? strobe_act : ~strobe_act;

	// Port C drivers; open-drain lines drive only a low
	assign drive = pc_dir_q
		| ((out_hs & lvl_act) ? 8'hff : 8'h00);
	assign port_c_oe_n = ~(drive
		& (~{8{ctrl_q[B_WIRED_OR]}} | ~pc_data_q));

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn || !ce);

	property p_pulse_two;
		(pb_wr && simple_mode && st_q == ST_IDLE) |=>
			strobe_act [*2] ##1 !strobe_act;
	endproperty
	a_pulse_two: assert property (p_pulse_two)
		else $error("strobe pulse not two cycles");

	property p_polarity;
		(st_q == ST_IDLE) |-> (strobe_out == !ctrl_q[B_POLARITY]);
	endproperty
	a_polarity: assert property (p_polarity)
		else $error("idle strobe level wrong");

	property p_latch;
		sel_edge |=> (latch_q == $past(pc_pin));
	endproperty
	a_latch: assert property (p_latch)
		else $error("latch missed capture");

	property p_flag_set;
		sel_edge |=> flag_q;
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("edge did not set flag");

	property p_flag_clr;
		(clr_arm_q && clr_access && !sel_edge) |=> !flag_q;
	endproperty
	a_flag_clr: assert property (p_flag_clr)
		else $error("flag not cleared");

	property p_irq;
		(flag_q && ctrl_q[B_IRQ_EN]) |-> strobe_irq ##1
			(strobe_irq == (flag_q && ctrl_q[B_IRQ_EN]));
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt request wrong");

	property p_wired_or;
		ctrl_q[B_WIRED_OR] |-> ((~port_c_oe_n & port_c_out) == 8'h00);
	endproperty
	a_wired_or: assert property (p_wired_or)
		else $error("open-drain line driven high");

	property p_interlock;
		(st_q == ST_HOLD && sel_edge) |=> (st_q == ST_IDLE) && !strobe_act;
	endproperty
	a_interlock: assert property (p_interlock)
		else $error("interlocked strobe not released");

	property p_three_state;
		(out_hs && lvl_act && !ctrl_q[B_WIRED_OR]) |->
			(port_c_oe_n == 8'h00);
	endproperty
	a_three_state: assert property (p_three_state)
		else $error("port C not driven during strobe");

	property p_mode_off;
		!single_chip_mode |=> !$rose(flag_q) && (st_q == ST_IDLE);
	endproperty
	a_mode_off: assert property (p_mode_off)
		else $error("handshake active outside single-chip mode");

	property p_bit7_ro;
		(wr_en && wr_sel == R_CTRL) |=> (ctrl_q[7] == 1'b0);
	endproperty
	a_bit7_ro: assert property (p_bit7_ro)
		else $error("control bit 7 written");

	c_simple: cover property (pb_wr && simple_mode);
	c_in_hs: cover property (in_hs && st_q == ST_HOLD ##[1:50] sel_edge);
	c_out_hs: cover property (out_hs && lat_wr ##[1:50] sel_edge);
	c_clear: cover property (clr_arm_q && clr_access);
endmodule : sph_handshake
`default_nettype wire

// *** hw/sph_sync.sv ***
// Three-stage pin synchroniser that accepts a change once stages agree
`default_nettype none
module sph_sync #(
	parameter int W = 9
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] agree;

	if (W < 1) begin : g_bad_w
		$error("sph_sync width must be at least one");
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else if (ce) begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	assign agree = ~(s2_q ^ s3_q);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else if (ce) begin
			q <= (s2_q & agree) | (q & ~agree);
		end
	end
endmodule : sph_sync
`default_nettype wire

// *** inc/sph_pkg.sv ***
// Register map, field layout and constants of the strobed parallel handshake
`default_nettype none
package sph_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 32;
	localparam int PORT_W = 8;
	// Register indices; byte address is four times the index
	localparam logic [15:0] IDX_CTRL = 16'h1002;
	localparam logic [15:0] IDX_PC_DATA = 16'h1003;
	localparam logic [15:0] IDX_PB_DATA = 16'h1004;
	localparam logic [15:0] IDX_PC_LATCH = 16'h1005;
	localparam logic [15:0] IDX_PC_DIR = 16'h1007;
	localparam logic [15:0] ADDR_CTRL = {IDX_CTRL[13:0], 2'b00};
	localparam logic [15:0] ADDR_PC_DATA = {IDX_PC_DATA[13:0], 2'b00};
	localparam logic [15:0] ADDR_PB_DATA = {IDX_PB_DATA[13:0], 2'b00};
	localparam logic [15:0] ADDR_PC_LATCH = {IDX_PC_LATCH[13:0], 2'b00};
	localparam logic [15:0] ADDR_PC_DIR = {IDX_PC_DIR[13:0], 2'b00};
	// Control register fields
	localparam int B_FLAG = 7;
	localparam int B_IRQ_EN = 6;
	localparam int B_WIRED_OR = 5;
	localparam int B_FULL_HS = 4;
	localparam int B_DIR_SEL = 3;
	localparam int B_PULSE_SEL = 2;
	localparam int B_EDGE_SEL = 1;
	localparam int B_POLARITY = 0;
	localparam logic [7:0] CTRL_RESET = 8'h03;
	localparam logic [7:0] PB_RESET = 8'h00;
	localparam logic [7:0] PC_RESET = 8'h00;
	localparam logic [7:0] DIR_RESET = 8'h00;
	localparam logic [7:0] LATCH_RESET = 8'h00;
	// Output strobe pulse length in bus clock periods
	localparam int STROBE_CYCLES = 2;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [2:0] {
		R_NONE,
		R_CTRL,
		R_PC_DATA,
		R_PB_DATA,
		R_PC_LATCH,
		R_PC_DIR
	} sph_reg_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_HOLD = 3'b010,
		ST_PULSE = 3'b100
	} sph_state_t;

	function automatic sph_reg_t sph_decode(input logic [ADDR_W-1:0] a);
		case (a)
			ADDR_CTRL: sph_decode = R_CTRL;
			ADDR_PC_DATA: sph_decode = R_PC_DATA;
			ADDR_PB_DATA: sph_decode = R_PB_DATA;
			ADDR_PC_LATCH: sph_decode = R_PC_LATCH;
			ADDR_PC_DIR: sph_decode = R_PC_DIR;
			default: sph_decode = R_NONE;
		endcase
	endfunction : sph_decode
endpackage : sph_pkg
`default_nettype wire

// *** verif/sph_far_end.sv ***
// Far-side model: external system trading port C data over the strobes
`default_nettype none
module sph_far_end (
	input wire logic aclk,
	input wire logic [7:0] port_c_out,
	input wire logic [7:0] port_c_oe_n,
	output logic strobe_in,
	output logic [7:0] port_c_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic drv;
	logic [7:0] dat, got, got_oe;
	// Lines nobody drives sit on the pull-ups, never on stale data
	assign port_c_in = (~port_c_oe_n & port_c_out)
		| (port_c_oe_n & (drv ? dat : 8'hff));
	initial begin
		strobe_in = 1'b0;
		drv = 1'b0;
		dat = 8'h00;
	end
	// Hold the strobe active n cycles; the release is the selected edge
	task automatic ack(input logic idle, input int n);
		strobe_in <= ~idle;
		repeat (n) @(posedge aclk);
		got <= port_c_in;
		got_oe <= port_c_oe_n;
		strobe_in <= idle;
	endtask : ack
	task automatic send(input logic [7:0] d, input logic idle, input int n);
		dat <= d;
		drv <= 1'b1;
		@(posedge aclk);
		ack(idle, n);
	endtask : send
endmodule : sph_far_end
`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking bench for the strobed parallel handshake block
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import sph_pkg::*;
	logic aclk, aresetn, ce, scm, stb_in, stb_out, irq, act_lvl;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [15:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb, ws;
	logic [2:0] prot;
	logic [1:0] bresp, rresp;
	logic [7:0] pb, pc_in, pc_out, pc_oe_n, v;
	logic [7:0] exp_d[$], exp_m[$];
	logic [1:0] exp_r[$], exp_b[$];
	int mismatches, checks_done, act_cnt, c0, seed;

	sph_handshake #(.STROBE_LEN(2)) DUT (.aclk(aclk), .aresetn(aresetn),
		.ce(ce), .s_axi_awaddr(awaddr), .s_axi_awprot(prot),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(prot),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .single_chip_mode(scm), .port_b_out(pb),
		.port_c_in(pc_in), .port_c_out(pc_out), .port_c_oe_n(pc_oe_n),
		.strobe_in(stb_in), .strobe_out(stb_out), .strobe_irq(irq));
	sph_far_end far (.aclk(aclk), .port_c_out(pc_out),
		.port_c_oe_n(pc_oe_n), .strobe_in(stb_in), .port_c_in(pc_in));

	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	// Counted on the falling edge so it never races the bench's reads
	always @(negedge aclk) if (stb_out === act_lvl) act_cnt++;

	task automatic chk(input string n, input logic [31:0] e,
			input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize
	task automatic to(input string n);
		mismatches++;
		$display("FAIL %s expected answer seen timeout", n);
		summarize();
	endtask : to
	task automatic wr(input logic [15:0] a, input logic [7:0] d,
			input logic [1:0] r = RESP_OKAY);
		int n;
		exp_b.push_back(r);
		awaddr <= a;
		wdata <= {24'($random(seed)), d};
		wstrb <= ws;
		prot <= 3'($random(seed));
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		if (n == 64) to("bvalid");
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [7:0] d,
			input logic [7:0] m = 8'hff, input logic [1:0] r = RESP_OKAY);
		int n;
		exp_d.push_back(d & m);
		exp_m.push_back(m);
		exp_r.push_back(r);
		araddr <= a;
		prot <= 3'($random(seed));
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		if (n == 64) to("rvalid");
	endtask : rd

	always @(posedge aclk) begin
		if (rvalid && rready) begin
			chk("rdata", {24'h0, exp_d[0]}, rdata & {24'hffffff, exp_m[0]});
			chk("rresp", exp_r[0], rresp);
			exp_d.delete(0);
			exp_m.delete(0);
			exp_r.delete(0);
		end
		if (bvalid && bready) begin
			chk("bresp", exp_b[0], bresp);
			exp_b.delete(0);
		end
	end

	initial begin
		seed = 32'h484a;
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, prot, act_cnt} = '0;
		{ce, scm, act_lvl, wstrb, ws} = {3'b111, 4'hf, 4'hf};
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk("pb_rst", PB_RESET, pb);
		chk("oe_rst", 8'hff, pc_oe_n);
		chk("stb_rst", 0, stb_out);
		chk("irq_rst", 0, irq);
		rd(ADDR_CTRL, 8'h03, 8'hfb);
		rd(ADDR_PC_DIR, 8'h00);
		rd(16'h4000, 8'h00, 8'hff, RESP_SLVERR);
		wr(16'h4004, 8'h55, RESP_SLVERR);
		ws = 4'h0;
		wr(ADDR_PB_DATA, 8'hff);
		ws = 4'hf;
		chk("pb_nostrb", 8'h00, pb);
		wr(ADDR_CTRL, 8'h83);
		rd(ADDR_CTRL, 8'h03);
		$display("test registers done");
		for (int p = 0; p < 2; p++) begin
			act_lvl = p[0];
			wr(ADDR_CTRL, {7'h0, p[0]});
			repeat (2) @(posedge aclk);
			c0 = act_cnt;
			v = 8'($random(seed));
			wr(ADDR_PB_DATA, v);
			repeat (6) @(posedge aclk);
			chk("stb_len", 2, act_cnt - c0);
			chk("pb", v, pb);
			chk("stb_idle", !p[0], stb_out);
		end
		scm <= 1'b0;
		c0 = act_cnt;
		wr(ADDR_PB_DATA, 8'h77);
		repeat (6) @(posedge aclk);
		chk("stb_off", 0, act_cnt - c0);
		scm <= 1'b1;
		$display("test simple strobe done");
		for (int e = 0; e < 2; e++) begin
			far.strobe_in <= e[0];
			repeat (8) @(posedge aclk);
			wr(ADDR_CTRL, {2'b01, 4'h0, e[0], 1'b1});
			v = 8'($random(seed));
			far.send(v, e[0], 3);
			repeat (8) @(posedge aclk);
			far.dat <= ~v;
			repeat (6) @(posedge aclk);
			chk("irq", 1, irq);
			rd(ADDR_CTRL, {2'b11, 4'h0, e[0], 1'b1});
			rd(ADDR_PC_LATCH, v);
			@(posedge aclk);
			chk("irq_clr", 0, irq);
		end
		wr(ADDR_CTRL, 8'h03);
		far.send(8'h5a, 1'b1, 2);
		repeat (8) @(posedge aclk);
		chk("irq_off", 0, irq);
		rd(ADDR_PC_LATCH, 8'h5a);
		rd(ADDR_CTRL, 8'h83);
		rd(ADDR_PC_LATCH, 8'h5a);
		rd(ADDR_CTRL, 8'h03);
		scm <= 1'b0;
		far.send(8'h11, 1'b1, 2);
		repeat (8) @(posedge aclk);
		rd(ADDR_CTRL, 8'h03);
		rd(ADDR_PC_LATCH, 8'h5a);
		scm <= 1'b1;
		$display("test input strobe done");
		far.strobe_in <= 1'b0;
		repeat (8) @(posedge aclk);
		wr(ADDR_CTRL, 8'h11);
		repeat (20) @(posedge aclk);
		chk("stb_ready", 1, stb_out);
		v = 8'($random(seed));
		far.send(v, 1'b0, 2);
		repeat (8) @(posedge aclk);
		chk("stb_neg", 0, stb_out);
		rd(ADDR_CTRL, 8'h91);
		rd(ADDR_PC_LATCH, v);
		@(posedge aclk);
		chk("stb_rearm", 1, stb_out);
		rd(ADDR_CTRL, 8'h11);
		wr(ADDR_CTRL, 8'h15);
		far.send(v, 1'b0, 2);
		repeat (8) @(posedge aclk);
		rd(ADDR_CTRL, 8'h95);
		act_lvl = 1'b1;
		c0 = act_cnt;
		rd(ADDR_PC_LATCH, v);
		repeat (6) @(posedge aclk);
		chk("stb_pulse", 2, act_cnt - c0);
		$display("test input handshake done");
		wr(ADDR_PC_DIR, 8'h00);
		wr(ADDR_CTRL, 8'h19);
		v = 8'($random(seed));
		wr(ADDR_PC_LATCH, v);
		@(posedge aclk);
		chk("stb_data", 1, stb_out);
		chk("pc_out", v, pc_out);
		chk("oe_float", 8'hff, pc_oe_n);
		far.drv <= 1'b0;
		far.ack(1'b0, 6);
		repeat (8) @(posedge aclk);
		chk("oe_all", 8'h00, far.got_oe);
		chk("pc_seen", v, far.got);
		chk("stb_ack", 0, stb_out);
		rd(ADDR_CTRL, 8'h99);
		wr(ADDR_PC_LATCH, ~v);
		rd(ADDR_CTRL, 8'h19);
		wr(ADDR_PC_DIR, 8'h0f);
		@(posedge aclk);
		chk("oe_dir", 8'hf0, pc_oe_n);
		$display("test output handshake done");
		wr(ADDR_CTRL, 8'h23);
		wr(ADDR_PC_DIR, 8'hf0);
		wr(ADDR_PC_DATA, 8'h3c);
		far.dat <= 8'ha5;
		far.drv <= 1'b1;
		repeat (6) @(posedge aclk);
		chk("oe_wor", 8'h3f, pc_oe_n);
		rd(ADDR_PC_DATA, 8'h35);
		wr(ADDR_CTRL, 8'h03);
		@(posedge aclk);
		chk("oe_pp", 8'h0f, pc_oe_n);
		$display("test port c drive done");
		summarize();
	end
endmodule : tb_top
`default_nettype wire
